/* File: shared/rsc_pkg.sv */
// Constants and types for the clock control and status register bank
package rsc_pkg;
    // ========================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TEMP_BASE_S = 30;
    localparam int unsigned TEMP_BASE_CYC = TEMP_BASE_S * CLK_HZ;
    localparam int unsigned RELOAD_MS = 100;
    localparam int unsigned RELOAD_CYC = RELOAD_MS * (CLK_HZ / 1000);
    localparam logic [3:0] TEMP_UNITS_MAX = 4'h8;

    // ========================================
    // Register indices, byte address is four times the index
    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;
    localparam logic [7:0] IDX_CTRL2 = 8'h01;
    localparam logic [7:0] IDX_CTRL3 = 8'h02;
    localparam logic [7:0] IDX_SQUARE_WAVE_PIN = 8'h0F;
    localparam logic [7:0] IDX_MISC = 8'h20;

    // ========================================
    // Second control register fields
    localparam int C2_TICK = 7;
    localparam int C2_WDT = 6;
    localparam int C2_TSG = 5;
    localparam int C2_ALM = 4;
    localparam int C2_CDT = 3;
    localparam int C2_TIMESTAMP_IRQ_ENABLE = 2;
    localparam int C2_AIE = 1;
    localparam int C2_CDIE = 0;
    localparam logic [7:0] C2_RST = 8'h00;
    localparam logic [7:0] C2_RW_MASK = 8'h07;
    localparam logic [7:0] C2_W0C_MASK = 8'hB8;
    localparam logic [7:0] C2_RO_MASK = 8'h40;

    // ========================================
    // Third control register fields
    localparam int C3_PWR_LSB = 5;
    localparam int C3_SWITCHOVER_STAMP_ENABLE = 4;
    localparam int C3_BF = 3;
    localparam int C3_BLF = 2;
    localparam int C3_BIE = 1;
    localparam int C3_BATTERY_LOW_IRQ_ENABLE = 0;
    localparam logic [7:0] C3_RST = 8'h00;
    localparam logic [7:0] C3_RW_MASK = 8'hF3;
    localparam logic [7:0] C3_W0C_MASK = 8'h08;

    // ========================================
    // Clock output control register fields
    localparam int CO_TCR_LSB = 6;
    localparam int CO_CALIB_RELOAD = 5;
    localparam int CO_COF_LSB = 0;
    localparam logic [7:0] CO_RW_MASK = 8'hC7;
    localparam logic [7:0] CO_RST = 8'h00;
    localparam logic [2:0] COF_REF = 3'h0;
    localparam logic [2:0] COF_1HZ = 3'h6;
    localparam logic [2:0] COF_OFF = 3'h7;
    localparam int DIV_W = 15;
    localparam int DIV_1HZ_BIT = 14;

    // ========================================
    // Misc status register fields
    localparam int MS_BUSY = 0;
    localparam int MS_IRQ = 1;

    typedef enum logic [1:0] {
        RSC_RL_IDLE,
        RSC_RL_ARMED,
        RSC_RL_BUSY
    } rsc_reload_t;
endpackage

/* File: design/rsc_regs.sv */
// Control and status register bank of the real-time clock, APB slave
// ========================================
// Notes on behaviour
// - Second control register at index 01h, all bits reset to zero.
// - Tick flag sets on tick event; host writes zero to clear it.
// - Watchdog flag sets on watchdog event; host writes never clear it.
// - Timestamp flag sets when timestamp pin pulled low; host clears it.
// - Alarm flag sets on alarm and holds until host clears it.
// - Countdown flag sets on countdown event; host clears it.
// - Timestamp enable gates timestamp flag onto interrupt.
// - Alarm enable gates alarm flag onto interrupt.
// - Countdown enable gates countdown flag onto interrupt.
// - Third control register at index 02h, all bits reset to zero.
// - Bits 7..5 select power management mode.
// - Stamp enable lets a switch-over capture a timestamp.
// - Switch-over flag sets on switch-over; host clears it.
// - Battery low flag follows battery state; writes cannot clear it.
// - Switch-over enable gates switch-over flag onto interrupt.
// - Battery low enable gates battery low flag onto interrupt.
// - Clock output register at 0Fh: period 7..6, frequency 2..0, reset zero.
// - Bits 4 and 3 of clock output register read zero.
// - Reload bit has no reset value and survives resets.
// - Temperature measured after reset, then every 4, 2, 1 min or 30 s.
// - Writing reload bit zero then one starts a reload finishing within 100 ms.
// - Frequency field picks 32768 Hz halving to 1024 Hz, 1 Hz, or off.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
module rsc_regs
    import rsc_pkg::*;
#(
    parameter int unsigned TEMP_CYC = rsc_pkg::TEMP_BASE_CYC,
    parameter int unsigned RELOAD_CYCLES = rsc_pkg::RELOAD_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rsc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tick_evt,
    input wire logic wdt_evt,
    input wire logic alarm_evt,
    input wire logic cdown_evt,
    input wire logic switchover_evt,
    input wire logic timestamp_input_n,
    input wire logic battery_low_in,
    input wire logic clk32k_in,
    output logic irq,
    output logic [2:0] power_manage_select,
    output logic switchover_stamp_enable,
    output logic stamp_capture,
    output logic [1:0] temp_period_select,
    output logic temp_measure,
    output logic calib_reload_busy,
    output logic square_wave_pin_o,
    output logic square_wave_pin_oe
);
    import rsc_pkg::*;

    if (TEMP_CYC < 1 || RELOAD_CYCLES < 1) begin : g_chk
        $error("rsc_regs: cycle counts must be at least one");
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ========================================
    // Pin synchronisers
    logic ts_s1_q, ts_s2_q, ts_s3_q;
    logic bl_s1_q, bl_s2_q;
    logic ck_s1_q, ck_s2_q, ck_s3_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_s1_q <= 1'b1;
            ts_s2_q <= 1'b1;
            ts_s3_q <= 1'b1;
            bl_s1_q <= 1'b0;
            bl_s2_q <= 1'b0;
            ck_s1_q <= 1'b0;
            ck_s2_q <= 1'b0;
            ck_s3_q <= 1'b0;
        end else begin
            ts_s1_q <= timestamp_input_n;
            ts_s2_q <= ts_s1_q;
            ts_s3_q <= ts_s2_q;
            bl_s1_q <= battery_low_in;
            bl_s2_q <= bl_s1_q;
            ck_s1_q <= clk32k_in;
            ck_s2_q <= ck_s1_q;
            ck_s3_q <= ck_s2_q;
        end
    end

    logic ts_fall;
    assign ts_fall = ts_s3_q & ~ts_s2_q;

    // ========================================
    // APB slave, one wait state per access
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [7:0] idx;
    logic hit, acc, wr_c2, wr_c3, wr_co;
    logic [7:0] c2_q, c2_d, c3_q, c3_d, co_q, co_d;
    logic calib_reload_q, calib_reload_d;
    logic irq_q, irq_d;
    logic busy_q;

    assign idx = paddr[IDX_LSB+:8];
    assign acc = psel & penable & pready_q;
    assign wr_c2 = acc & pwrite & (idx == IDX_CTRL2);
    assign wr_c3 = acc & pwrite & (idx == IDX_CTRL3);
    assign wr_co = acc & pwrite & (idx == IDX_SQUARE_WAVE_PIN);

    always_comb begin
        logic [7:0] rd;
        rd = 8'h00;
        hit = 1'b1;
        if (paddr[IDX_LSB-1:0] != '0) begin
            hit = 1'b0;
        end else if (idx == IDX_CTRL2) begin
            rd = c2_q;
        end else if (idx == IDX_CTRL3) begin
            rd = c3_q;
        end else if (idx == IDX_SQUARE_WAVE_PIN) begin
            rd = co_q & CO_RW_MASK;
            rd[CO_CALIB_RELOAD] = calib_reload_q;
        end else if (idx == IDX_MISC) begin
            rd[MS_BUSY] = busy_q;
            rd[MS_IRQ] = irq_q;
        end else begin
            hit = 1'b0;
        end
        pready_d = psel & penable & ~pready_q;
        pslverr_d = pready_d & ~hit;
        prdata_d = (pready_d & ~pwrite & hit) ? {24'h000000, rd} : 32'h00000000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ========================================
    // Control registers and interrupt
    logic [7:0] c2_evt, c3_evt;
    logic stamp_q, stamp_d;

    always_comb begin
        c2_evt = 8'h00;
        c2_evt[C2_TICK] = tick_evt;
        c2_evt[C2_WDT] = wdt_evt;
        c2_evt[C2_TSG] = ts_fall;
        c2_evt[C2_ALM] = alarm_evt;
        c2_evt[C2_CDT] = cdown_evt;
        c3_evt = 8'h00;
        c3_evt[C3_BF] = switchover_evt;
        c2_d = c2_q;
        if (wr_c2) begin
            // Write zero clears a flag, write one leaves it
            c2_d = (c2_q & C2_RO_MASK) | (c2_q & pwdata[7:0] & C2_W0C_MASK)
                | (pwdata[7:0] & C2_RW_MASK);
        end
        c2_d = c2_d | c2_evt; // Set wins over a clear in the same cycle
        c3_d = c3_q;
        if (wr_c3) begin
            c3_d = (c3_q & C3_W0C_MASK & pwdata[7:0]) | (pwdata[7:0] & C3_RW_MASK);
        end
        c3_d = c3_d | c3_evt;
        c3_d[C3_BLF] = bl_s2_q;
        co_d = co_q;
        if (wr_co) begin
            co_d = pwdata[7:0] & CO_RW_MASK;
        end
        stamp_d = switchover_evt & c3_q[C3_SWITCHOVER_STAMP_ENABLE];
        irq_d = (c2_q[C2_TICK])
            | (c2_q[C2_TSG] & c2_q[C2_TIMESTAMP_IRQ_ENABLE])
            | (c2_q[C2_ALM] & c2_q[C2_AIE])
            | (c2_q[C2_CDT] & c2_q[C2_CDIE])
            | (c3_q[C3_BF] & c3_q[C3_BIE])
            | (c3_q[C3_BLF] & c3_q[C3_BATTERY_LOW_IRQ_ENABLE]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c2_q <= C2_RST;
            c3_q <= C3_RST;
            co_q <= CO_RST;
            stamp_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            c2_q <= c2_d;
            c3_q <= c3_d;
            co_q <= co_d;
            stamp_q <= stamp_d;
            irq_q <= irq_d;
        end
    end

    // Reload bit is kept through resets, so it has no reset branch
    always_comb begin
        calib_reload_d = wr_co ? pwdata[CO_CALIB_RELOAD] : calib_reload_q;
    end

    always_ff @(posedge pclk) begin
        calib_reload_q <= calib_reload_d;
    end

    // ========================================
    // Calibration reload sequence
    rsc_reload_t rl_q, rl_d;
    logic [31:0] rl_cnt_q, rl_cnt_d;
    logic busy_d;

    always_comb begin
        rl_d = rl_q;
        rl_cnt_d = rl_cnt_q;
        case (rl_q)
            RSC_RL_IDLE: begin
                if (wr_co && !pwdata[CO_CALIB_RELOAD]) begin
                    rl_d = RSC_RL_ARMED;
                end
            end
            RSC_RL_ARMED: begin
                if (wr_co && pwdata[CO_CALIB_RELOAD]) begin
                    rl_d = RSC_RL_BUSY;
                    rl_cnt_d = 32'h00000000;
                end
            end
            RSC_RL_BUSY: begin
                if (rl_cnt_q >= RELOAD_CYCLES - 1) begin
                    rl_d = RSC_RL_IDLE;
                end else begin
                    rl_cnt_d = rl_cnt_q + 32'h00000001;
                end
            end
            default: begin
                rl_d = RSC_RL_IDLE;
            end
        endcase
        busy_d = (rl_d == RSC_RL_BUSY);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rl_q <= RSC_RL_IDLE;
            rl_cnt_q <= 32'h00000000;
            busy_q <= 1'b0;
        end else begin
            rl_q <= rl_d;
            rl_cnt_q <= rl_cnt_d;
            busy_q <= busy_d;
        end
    end

    // ========================================
    // Temperature measurement pacing in 30 s units
    logic [31:0] tb_cnt_q, tb_cnt_d;
    logic [3:0] tu_cnt_q, tu_cnt_d, tu_max;
    logic first_q, first_d, temp_q, temp_d;

    always_comb begin
        tu_max = TEMP_UNITS_MAX >> co_q[CO_TCR_LSB+:2];
        tb_cnt_d = tb_cnt_q + 32'h00000001;
        tu_cnt_d = tu_cnt_q;
        temp_d = 1'b0;
        first_d = 1'b0;
        if (first_q) begin
            temp_d = 1'b1;
            tb_cnt_d = 32'h00000000;
            tu_cnt_d = 4'h0;
        end else if (tb_cnt_q >= TEMP_CYC - 1) begin
            tb_cnt_d = 32'h00000000;
            if (tu_cnt_q + 4'h1 >= tu_max) begin
                tu_cnt_d = 4'h0;
                temp_d = 1'b1;
            end else begin
                tu_cnt_d = tu_cnt_q + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_cnt_q <= 32'h00000000;
            tu_cnt_q <= 4'h0;
            first_q <= 1'b1;
            temp_q <= 1'b0;
        end else begin
            tb_cnt_q <= tb_cnt_d;
            tu_cnt_q <= tu_cnt_d;
            first_q <= first_d;
            temp_q <= temp_d;
        end
    end

    // ========================================
    // Square wave output, open drain, pulls low only
    logic [DIV_W-1:0] div_q, div_d;
    logic sq_oe_q, sq_oe_d;

    always_comb begin
        logic lvl;
        logic [2:0] cof;
        lvl = 1'b1;
        cof = co_q[CO_COF_LSB+:3];
        div_d = (ck_s2_q & ~ck_s3_q) ? div_q + 15'h0001 : div_q;
        if (cof == COF_REF) begin
            lvl = ck_s3_q;
        end else if (cof == COF_1HZ) begin
            lvl = div_q[DIV_1HZ_BIT];
        end else if (cof != COF_OFF) begin
            lvl = div_q[cof - 3'h1];
        end
        sq_oe_d = (cof != COF_OFF) & ~lvl;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= '0;
            sq_oe_q <= 1'b0;
        end else begin
            div_q <= div_d;
            sq_oe_q <= sq_oe_d;
        end
    end

    // ========================================
    // Outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;
    assign power_manage_select = c3_q[C3_PWR_LSB+:3];
    assign switchover_stamp_enable = c3_q[C3_SWITCHOVER_STAMP_ENABLE];
    assign stamp_capture = stamp_q;
    assign temp_period_select = co_q[CO_TCR_LSB+:2];
    assign temp_measure = temp_q;
    assign calib_reload_busy = busy_q;
    assign square_wave_pin_o = 1'b0;
    assign square_wave_pin_oe = sq_oe_q;

    // ========================================
    // Assertions
    sequence s_arm;
        wr_co && !pwdata[CO_CALIB_RELOAD];
    endsequence
    sequence s_fire;
        wr_co && pwdata[CO_CALIB_RELOAD];
    endsequence

    a_alarm_irq: assert property (c2_q[C2_ALM] && c2_q[C2_AIE] |=> irq_q)
        else $error("alarm flag enabled but no interrupt");
    a_irq_release: assert property (!c2_q[C2_TICK] && !(c2_q[C2_TSG] && c2_q[C2_TIMESTAMP_IRQ_ENABLE])
        && !(c2_q[C2_ALM] && c2_q[C2_AIE]) && !(c2_q[C2_CDT] && c2_q[C2_CDIE])
        && !(c3_q[C3_BF] && c3_q[C3_BIE]) && !(c3_q[C3_BLF] && c3_q[C3_BATTERY_LOW_IRQ_ENABLE])
        |=> !irq_q)
        else $error("interrupt held with no enabled flag");
    a_ts_gate: assert property (c2_q[C2_TSG] && !c2_q[C2_TIMESTAMP_IRQ_ENABLE] && !c2_q[C2_TICK]
        && !(c2_q[C2_ALM] && c2_q[C2_AIE]) && !(c2_q[C2_CDT] && c2_q[C2_CDIE])
        && !(c3_q[C3_BF] && c3_q[C3_BIE]) && !(c3_q[C3_BLF] && c3_q[C3_BATTERY_LOW_IRQ_ENABLE])
        |=> !irq_q)
        else $error("masked timestamp flag raised interrupt");
    a_wdt_sticky: assert property (c2_q[C2_WDT] |=> c2_q[C2_WDT])
        else $error("watchdog flag cleared");
    a_alarm_set: assert property (alarm_evt |=> c2_q[C2_ALM])
        else $error("alarm event lost");
    a_blf_track: assert property (bl_s2_q |=> c3_q[C3_BLF])
        else $error("battery low flag not following");
    a_unused_zero: assert property (pready_d && !pwrite && idx == IDX_SQUARE_WAVE_PIN
        |=> prdata_q[4:3] == 2'b00)
        else $error("unused clock output bits read nonzero");
    a_reload_arm: assert property (rl_q == RSC_RL_IDLE ##0 s_arm
        |=> rl_q == RSC_RL_ARMED)
        else $error("reload not armed by zero write");
    a_reload_start: assert property (rl_q == RSC_RL_ARMED ##0 s_fire
        |=> busy_q)
        else $error("reload not started by zero then one");
    a_reload_bound: assert property (busy_q |-> rl_cnt_q < RELOAD_CYCLES)
        else $error("reload exceeds its time limit");
    a_stamp_gate: assert property (stamp_q |-> $past(c3_q[C3_SWITCHOVER_STAMP_ENABLE]))
        else $error("stamp captured while disabled");
    a_cof_off: assert property (co_q[CO_COF_LSB+:3] == COF_OFF |=> !sq_oe_q)
        else $error("square wave driven while off");
    a_temp_first: assert property ($fell(first_q) |-> temp_q)
        else $error("no measurement after reset");
endmodule

/* File: dv/rsc_host.sv */
// APB host model that reaches the register bank
`timescale 1ns/10ps
module rsc_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [rsc_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import rsc_pkg::*;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // ========================================
    // Transfer
    // Request held until pready or 16 cycles; released data turns inverted so stale values never match
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic hung);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        hung = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

/* File: dv/tb.sv */
// Self-checking testbench of the clock control and status register bank
`timescale 1ns/10ps
module tb;
    import rsc_pkg::*;
    localparam int TEMP_N = 50;
    localparam int RELOAD_N = 20;
    localparam logic [11:0] A2 = 12'h004;
    localparam logic [11:0] A3 = 12'h008;
    localparam logic [11:0] AO = 12'h03C;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic tick_evt, wdt_evt, alarm_evt, cdown_evt, switchover_evt, ts_n, bl_in, clk32k_in;
    logic [2:0] pwr_sel;
    logic stamp_en, stamp_capture, temp_measure, busy, sq_o, sq_oe, e, h, prev;
    logic [1:0] tp_sel;
    logic [7:0] d, c2, c3;
    logic [31:0] seed;
    int error_cnt, checked, n, m, i, x;
    rsc_host u_rsc_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    rsc_regs #(.TEMP_CYC(TEMP_N), .RELOAD_CYCLES(RELOAD_N)) u_rsc_regs (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tick_evt(tick_evt), .wdt_evt(wdt_evt), .alarm_evt(alarm_evt), .cdown_evt(cdown_evt),
        .switchover_evt(switchover_evt), .timestamp_input_n(ts_n), .battery_low_in(bl_in),
        .clk32k_in(clk32k_in), .irq(irq), .power_manage_select(pwr_sel),
        .switchover_stamp_enable(stamp_en), .stamp_capture(stamp_capture),
        .temp_period_select(tp_sel), .temp_measure(temp_measure), .calib_reload_busy(busy),
        .square_wave_pin_o(sq_o), .square_wave_pin_oe(sq_oe));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Reference kept well below pclk so the three-flop synchroniser sees every level
    initial begin
        clk32k_in = 1'b0;
        forever #61 clk32k_in = ~clk32k_in;
    end
    // ========================================
    // Helpers
    task automatic tally_and_finish;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xf(input logic w, input logic [11:0] a, input logic [7:0] v);
        u_rsc_host.xfer(w, a, {24'h0, v}, r, e, h);
        if (h) begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    function automatic logic xirq(input logic [7:0] a, input logic [7:0] b);
        return a[7] | (a[5] & a[2]) | (a[4] & a[1]) | (a[3] & a[0]) | (b[3] & b[1]) | (b[2] & b[0]);
    endfunction
    // Event bits: tick, watchdog, alarm, countdown, switch-over, timestamp pin
    task automatic ev(input logic [5:0] k);
        @(posedge pclk);
        {tick_evt, wdt_evt, alarm_evt, cdown_evt, switchover_evt} <= k[4:0];
        ts_n <= ~k[5];
        @(posedge pclk);
        {tick_evt, wdt_evt, alarm_evt, cdown_evt, switchover_evt} <= 5'h00;
        #1;
        if (k[0]) chk(stamp_capture, c3[4]);
        repeat (4) @(posedge pclk);
        ts_n <= 1'b1;
        repeat (6) @(posedge pclk);
        c2 = c2 | {k[4], k[3], k[5], k[2], k[1], 3'b000};
        c3 = c3 | {4'h0, k[0], 3'b000};
    endtask
    task automatic gap(output int g);
        g = 0;
        do begin
            @(posedge pclk);
            g++;
        end while (temp_measure !== 1'b1 && g < 1000);
    endtask
    initial begin
        #(25 * 90000);
        error_cnt++;
        tally_and_finish;
    end
    // ========================================
    // Main sequence
    initial begin
        seed = 32'h95c8ecd7;
        presetn = 1'b0;
        {tick_evt, wdt_evt, alarm_evt, cdown_evt, switchover_evt, bl_in} = 6'h00;
        ts_n = 1'b1;
        c2 = 8'h00;
        c3 = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        xf(0, A2, 0);
        chk(r, 32'h0);
        xf(0, A3, 0);
        chk(r, 32'h0);
        xf(0, AO, 0);
        chk(r & 32'hDF, 32'h0);
        xf(0, 12'h0FC, 0);
        chk({r[30:0], e}, 32'h1);
        xf(1, 12'h005, 8'hFF);
        chk(e, 1'b1);
        $display("test reset_and_refusal done");
        for (i = 0; i < 12; i++) begin
            x = $random(seed);
            d = (i == 0) ? 8'hFF : x[7:0];
            xf(1, A2, d);
            c2 = (c2 & d & 8'hB8) | (c2 & 8'h40) | (d & 8'h07);
            x = $random(seed);
            d = (i == 0) ? 8'hFF : x[7:0];
            xf(1, A3, d);
            x = $random(seed);
            bl_in <= (i == 0) | x[0];
            c3 = (d & 8'hF3) | (c3 & d & 8'h08) | {5'h0, (i == 0) | x[0], 2'b00};
            x = $random(seed);
            ev((i == 0) ? 6'h3F : x[5:0]);
            xf(0, A2, 0);
            chk(r, {24'h0, c2});
            xf(0, A3, 0);
            chk(r, {24'h0, c3});
            chk(irq, xirq(c2, c3));
            chk({pwr_sel, stamp_en}, c3[7:4]);
            xf(0, 12'h080, 0);
            chk(r, {30'h0, xirq(c2, c3), 1'b0});
        end
        xf(1, A2, 8'h00);
        xf(1, A3, 8'h00);
        bl_in <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(irq, 1'b0);
        xf(0, A2, 0);
        chk(r, {24'h0, c2 & 8'h40});
        $display("test flags_and_irq done");
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            d[5] = 1'b0;
            d[7:6] = i;
            xf(1, AO, d);
            xf(0, AO, 0);
            chk(r, {24'h0, d & 8'hC7});
            chk(tp_sel, d[7:6]);
            gap(n);
            gap(n);
            chk(n, TEMP_N * (8 >> i));
        end
        $display("test clock_output_control done");
        for (i = 0; i < 9; i++) begin
            xf(1, AO, (i > 6) ? 8'h07 : i[7:0]);
            m = 0;
            prev = sq_oe;
            for (n = 0; n < 312; n++) begin
                @(posedge pclk);
                #1;
                m += (sq_oe === 1'b1 && prev !== 1'b1) ? 1 : 0;
                prev = sq_oe;
            end
            x = (i > 5) ? 0 : (64 >> i);
            chk(m >= x - 1 && m <= x + 1, 1'b1);
            chk(sq_o, 1'b0);
        end
        $display("test square_wave done");
        xf(1, AO, 8'h00);
        xf(1, AO, 8'h20);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (busy !== 1'b1 && n < 8);
        m = 0;
        do begin
            @(posedge pclk);
            m++;
        end while (busy === 1'b1 && m < 100);
        chk(m, RELOAD_N);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xf(0, AO, 0);
        chk(r, 32'h20);
        xf(0, A2, 0);
        chk(r, 32'h0);
        $display("test reload_and_second_reset done");
        tally_and_finish;
    end
endmodule
